// ===== hdl/aaau_pkg.sv
// aaau_pkg: constants shared by the accumulator abs/add datapath
// assumes 16-bit instruction words and a 32-bit accumulator
package aaau_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int PC_W = 12;
  localparam int DMA_W = 7;
  localparam int SHIFT_W = 4;
  // instruction field positions
  localparam int OPC_HI = 15;
  localparam int OPC_ADD_LO = 12;
  localparam int SHIFT_HI = 11;
  localparam int SHIFT_LO = 8;
  localparam int IND_BIT = 7;
  localparam int ARP_BIT = 0;
  localparam int OPC_ADD_HIGH_OP_LO = 8;
  // opcodes
  localparam logic [15:0] OP_ABS = 16'h7F88;
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [7:0] OP_ADD_HIGH_OP = 8'h60;
  // special values
  localparam logic [31:0] ACC_MOST_NEG = 32'h80000000;
  localparam logic [31:0] ACC_MOST_POS = 32'h7FFFFFFF;
  localparam logic [31:0] ACC_RST = 32'h00000000;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  // operation decode
  typedef enum logic [3:0] {
    AAAU_OP_NONE = 4'b0001,
    AAAU_OP_ABS = 4'b0010,
    AAAU_OP_ADD = 4'b0100,
    AAAU_OP_ADD_HIGH_OP = 4'b1000
  } aaau_op_t;
endpackage : aaau_pkg

// ===== hdl/aaau_abs.sv
// aaau_abs: absolute value of the accumulator, combinational
// assumes caller registers the result
`timescale 1ns/1ps
`default_nettype none
module aaau_abs
  import aaau_pkg::*;
(
  // operand and mode
  input wire logic [ACC_W-1:0] acc_i,
  input wire logic ovm_i,
  // result
  output logic [ACC_W-1:0] abs_o
);
  // negate negatives, special-case most negative
  always_comb begin
    if (acc_i == ACC_MOST_NEG) begin
      abs_o = ovm_i ? ACC_MOST_POS : ACC_MOST_NEG;
    end else if (acc_i[ACC_W-1]) begin
      abs_o = ACC_W'(~acc_i + ACC_W'(1));
    end else begin
      abs_o = acc_i;
    end
  end
endmodule : aaau_abs
`default_nettype wire

// ===== hdl/aaau_unit.sv
// aaau_unit: execution of abs, add-with-shift and add-high
// assumes decoder presents one instruction per cycle with its operand
`timescale 1ns/1ps
`default_nettype none
module aaau_unit
  import aaau_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // instruction from decoder
  input wire logic instr_valid_i,
  input wire logic [WORD_W-1:0] instr_i,
  input wire logic ovm_i,
  // operand from data memory
  input wire logic [WORD_W-1:0] dmem_data_i,
  // results
  output logic [ACC_W-1:0] acc_o,
  output logic [PC_W-1:0] pc_o,
  output logic [DMA_W-1:0] dmem_addr_o,
  output logic indirect_o,
  output logic aux_pointer_select_o,
  output logic done_o
);
  logic [ACC_W-1:0] acc;
  logic [PC_W-1:0] pc;
  logic [DMA_W-1:0] dma;
  logic ind;
  logic aux_pointer_select;
  logic done;
  logic [ACC_W-1:0] next_acc;
  logic [PC_W-1:0] next_pc;
  logic [DMA_W-1:0] next_dma;
  logic next_ind;
  logic next_arp;
  logic next_done;
  logic [ACC_W-1:0] abs_val;
  aaau_op_t op;

  // sign-extend operand and shift left, zero-filling low bits
  function automatic logic [ACC_W-1:0] shift_ext(input logic [WORD_W-1:0] d,
                                                 input logic [SHIFT_W-1:0] s);
    logic [ACC_W-1:0] ext;
    ext = {{(ACC_W-WORD_W){d[WORD_W-1]}}, d};
    return ext << s;
  endfunction : shift_ext

  // classify instruction
  always_comb begin
    if (!instr_valid_i) begin
      op = AAAU_OP_NONE;
    end else if (instr_i == OP_ABS) begin
      op = AAAU_OP_ABS;
    end else if (instr_i[OPC_HI:OPC_ADD_LO] == OP_ADD) begin
      op = AAAU_OP_ADD;
    end else if (instr_i[OPC_HI:OPC_ADD_HIGH_OP_LO] == OP_ADD_HIGH_OP) begin
      op = AAAU_OP_ADD_HIGH_OP;
    end else begin
      op = AAAU_OP_NONE;
    end
  end

  aaau_abs u_abs (
    .acc_i(acc),
    .ovm_i(ovm_i),
    .abs_o(abs_val)
  );

  // next-state for accumulator, pc and address fields
  always_comb begin
    next_acc = acc;
    next_pc = pc;
    next_dma = dma;
    next_ind = ind;
    next_arp = aux_pointer_select;
    next_done = 1'b0;
    unique case (op)
      AAAU_OP_ABS: begin
        next_acc = abs_val;
      end
      AAAU_OP_ADD: begin
        next_acc = ACC_W'(acc + shift_ext(dmem_data_i, instr_i[SHIFT_HI:SHIFT_LO]));
      end
      AAAU_OP_ADD_HIGH_OP: begin
        next_acc = {WORD_W'(acc[ACC_W-1:WORD_W] + dmem_data_i), acc[WORD_W-1:0]};
      end
      AAAU_OP_NONE: begin
        next_acc = acc;
      end
    endcase
    if (op != AAAU_OP_NONE) begin
      next_pc = PC_W'(pc + PC_STEP);
      next_done = 1'b1;
      // abs leaves the address outputs as they were
      if (op != AAAU_OP_ABS) begin
        next_ind = instr_i[IND_BIT];
      end
      if (op != AAAU_OP_ABS && !instr_i[IND_BIT]) begin
        next_dma = instr_i[DMA_W-1:0];
      end
      if (op != AAAU_OP_ABS && instr_i[IND_BIT]) begin
        next_arp = instr_i[ARP_BIT];
      end
    end
  end

  // register state
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      acc <= ACC_RST;
      pc <= PC_RST;
      dma <= '0;
      ind <= 1'b0;
      aux_pointer_select <= 1'b0;
      done <= 1'b0;
    end else begin
      acc <= next_acc;
      pc <= next_pc;
      dma <= next_dma;
      ind <= next_ind;
      aux_pointer_select <= next_arp;
      done <= next_done;
    end
  end

  assign acc_o = acc;
  assign pc_o = pc;
  assign dmem_addr_o = dma;
  assign indirect_o = ind;
  assign aux_pointer_select_o = aux_pointer_select;
  assign done_o = done;

  // checks
  property p_abs_pos;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ABS && !acc[ACC_W-1]) |=> (acc == $past(acc));
  endproperty
  a_abs_pos: assert property (p_abs_pos) else $error("abs changed positive acc");

  property p_abs_neg;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ABS && acc[ACC_W-1] && acc != ACC_MOST_NEG) |=> (acc == ACC_W'(-$past(acc)));
  endproperty
  a_abs_neg: assert property (p_abs_neg) else $error("abs did not negate");

  property p_abs_minneg;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ABS && acc == ACC_MOST_NEG && !ovm_i) |=> (acc == ACC_MOST_NEG);
  endproperty
  a_abs_minneg: assert property (p_abs_minneg) else $error("abs min wrong without ovm");

  property p_abs_sat;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ABS && acc == ACC_MOST_NEG && ovm_i) |=> (acc == ACC_MOST_POS);
  endproperty
  a_abs_sat: assert property (p_abs_sat) else $error("abs did not saturate");

  // operand sign-extended to full width before the shift
  property p_add;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ADD)
      |=> (acc == ACC_W'($past(acc) + (ACC_W'($signed($past(dmem_data_i))) << $past(instr_i[SHIFT_HI:SHIFT_LO]))));
  endproperty
  a_add: assert property (p_add) else $error("add with shift wrong");

  property p_dir_addr;
    @(posedge clk_i) disable iff (!rstn_i)
      (op inside {AAAU_OP_ADD, AAAU_OP_ADD_HIGH_OP} && !instr_i[IND_BIT])
      |=> (!indirect_o && dmem_addr_o == $past(instr_i[DMA_W-1:0]));
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");

  sequence s_exec;
    op != AAAU_OP_NONE;
  endsequence
  property p_pc;
    @(posedge clk_i) disable iff (!rstn_i)
      s_exec |=> (pc == PC_W'($past(pc) + PC_STEP)) && done_o;
  endproperty
  a_pc: assert property (p_pc) else $error("pc not advanced by one");

  property p_add_high_op;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ADD_HIGH_OP) |=> (acc[ACC_W-1:WORD_W] == WORD_W'($past(acc[ACC_W-1:WORD_W]) + $past(dmem_data_i)));
  endproperty
  a_add_high_op: assert property (p_add_high_op) else $error("add high wrong");

  property p_add_high_op_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ADD_HIGH_OP) |=> $stable(acc[WORD_W-1:0]);
  endproperty
  a_add_high_op_low: assert property (p_add_high_op_low) else $error("add high touched low half");

  property p_shift_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_ADD && acc == '0 && instr_i[SHIFT_HI:SHIFT_LO] != '0)
      |=> ((acc << (ACC_W - int'($past(instr_i[SHIFT_HI:SHIFT_LO])))) == '0);
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("shift did not zero fill");

  // indirect access records pointer select, keeps offset
  property p_ind_addr;
    @(posedge clk_i) disable iff (!rstn_i)
      (op inside {AAAU_OP_ADD, AAAU_OP_ADD_HIGH_OP} && instr_i[IND_BIT])
      |=> (indirect_o && aux_pointer_select_o == $past(instr_i[ARP_BIT]) && $stable(dmem_addr_o));
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect pointer select wrong");

  // refused slot leaves accumulator and pc alone
  property p_refused;
    @(posedge clk_i) disable iff (!rstn_i)
      (op == AAAU_OP_NONE) |=> ($stable(acc) && $stable(pc) && !done_o);
  endproperty
  a_refused: assert property (p_refused) else $error("refused slot changed state");

  // completion flag is high for one cycle after each executed slot, so it stays high across back-to-back slots
  sequence s_done_pulse;
    done_o ##1 !done_o;
  endsequence
  property p_done_pulse;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_exec ##1 (op == AAAU_OP_NONE)) |-> s_done_pulse;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a one-cycle pulse");
endmodule : aaau_unit
`default_nettype wire

// ===== testbench/aaau_mem_model.sv
// aaau_mem_model: operand memory in front of the unit
// assumes operand follows the instruction in the same cycle
`timescale 1ns/1ps
`default_nettype none
module aaau_mem_model
  import aaau_pkg::*;
(
  // instruction seen by memory
  input wire logic [WORD_W-1:0] instr_i,
  // operand word
  output logic [WORD_W-1:0] data_o
);
  logic [DMA_W-1:0] addr;
  // direct offset, or one of two aux addresses
  assign addr = instr_i[IND_BIT] ? (instr_i[ARP_BIT] ? 7'h7F : 7'h05) : instr_i[DMA_W-1:0];
  // fixed contents, two corner words at the bottom
  assign data_o = addr == 7'h00 ? 16'h8000 : addr == 7'h01 ? 16'hFFFF : {addr, 2'h2, ~addr};
endmodule : aaau_mem_model
`default_nettype wire

// ===== testbench/testbench.sv
// testbench: corner and random abs, add, add-high traffic
// assumes memory model answers combinationally
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aaau_pkg::*;
  logic clk_i = 1'b0, rstn_i = 0, instr_valid_i = 0, ovm_i = 0, done_o, pend = 0, ind_o, arp_o, m_ind, m_arp;
  logic [15:0] instr_i = 16'h0000, dmem_data_i;
  logic [31:0] acc_o, m_acc, r;
  logic [11:0] pc_o, m_pc;
  logic [6:0] dma_o, m_dma;
  logic [52:0] q [$];
  int bad_count = 0, cmp_count = 0, seed = 32'h378BD069, n;
  // unit and its operand memory
  aaau_unit DUT (.clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .ovm_i(ovm_i), .dmem_data_i(dmem_data_i), .acc_o(acc_o), .pc_o(pc_o), .dmem_addr_o(dma_o),
    .indirect_o(ind_o), .aux_pointer_select_o(arp_o), .done_o(done_o));
  aaau_mem_model mem (.instr_i(instr_i), .data_o(dmem_data_i));
  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // drive one slot, note the expected result
  task automatic issue(input logic v, input logic [15:0] ins, input logic ov);
    logic [31:0] op;
    @(negedge clk_i);
    instr_valid_i = v;
    instr_i = ins;
    ovm_i = ov;
    #1;
    op = {{16{dmem_data_i[15]}}, dmem_data_i};
    pend = v && (ins == OP_ABS || ins[15:12] == OP_ADD || ins[15:8] == OP_ADD_HIGH_OP);
    if (!pend)
      return;
    if (ins == OP_ABS) begin
      if (m_acc == ACC_MOST_NEG)
        m_acc = ov ? ACC_MOST_POS : ACC_MOST_NEG;
      else if (m_acc[31])
        m_acc = -m_acc;
    end else if (ins[15:12] == OP_ADD)
      m_acc = m_acc + (op << ins[11:8]);
    else
      m_acc = m_acc + {dmem_data_i, 16'h0000};
    if (ins != OP_ABS) begin
      m_ind = ins[7];
      if (ins[7])
        m_arp = ins[0];
      else
        m_dma = ins[6:0];
    end
    m_pc = m_pc + PC_STEP;
    q.push_back({m_acc, m_pc, m_dma, m_ind, m_arp});
  endtask : issue
  task automatic do_reset;
    issue(0, 16'h0000, 0);
    rstn_i = 0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1;
    m_acc = ACC_RST;
    m_pc = PC_RST;
    m_dma = 7'h00;
    m_ind = 1'b0;
    m_arp = 1'b0;
  endtask : do_reset
  // compare each completion with the oldest note
  always @(negedge clk_i) begin
    check({31'h0, done_o}, {31'h0, pend});
    if (done_o === 1'b1 && q.size() > 0) begin
      check(acc_o, q[0][52:21]);
      check({20'h0, pc_o}, {20'h0, q[0][20:9]});
      check({25'h0, dma_o}, {25'h0, q[0][8:2]});
      check({30'h0, ind_o, arp_o}, {30'h0, q[0][1:0]});
      void'(q.pop_front());
    end
  end
  // corners, second reset, then random mix
  initial begin
    do_reset();
    issue(1, {OP_ADD_HIGH_OP, 8'h00}, 0);
    issue(1, OP_ABS, 0);
    issue(1, OP_ABS, 1);
    issue(1, OP_ABS, 1);
    issue(1, 16'h0F01, 0);
    do_reset();
    issue(1, 16'h0301, 0);
    issue(1, OP_ABS, 0);
    repeat (500) begin
      r = $random(seed);
      n = r[18:16];
      issue(n < 5, n == 0 ? OP_ABS : n == 3 ? {OP_ADD_HIGH_OP, r[7:0]} : n == 4 ? 16'h7F80 : {OP_ADD, r[11:0]}, r[20]);
    end
    issue(0, 16'h0000, 0);
    for (n = 0; n < 9 && q.size() > 0; n++)
      @(negedge clk_i);
    if (q.size() > 0)
      bad_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
